// >>> shared/pwr_frame_pkg.sv
// constants for the suspend, frame tick and audio clock control block
package pwr_frame_pkg;
	localparam int  clock_mhz             = 100;
	localparam int  frame_period_us       = 1000;
	localparam int  frame_cycles          = frame_period_us * clock_mhz;
	localparam int  frame_tick_high       = frame_cycles / 2;
	localparam int  reference_mhz         = 12;
	localparam int  audio_clock_low_mhz   = 48;
	localparam int  audio_clock_high_mhz  = 72;
	localparam int  suspend_idle_us       = 3000;
	localparam int  suspend_idle_cycles   = suspend_idle_us * clock_mhz;
	localparam int  lock_window_cycles    = frame_cycles / 100;

	typedef enum logic [1:0] {
		st_clock_wait = 2'b00,
		st_normal     = 2'b01,
		st_low_power  = 2'b10,
		st_waking     = 2'b11
	} power_state_t;
endpackage : pwr_frame_pkg

// >>> logic/usb_suspend_frame_clock_ctrl.sv
// power state, frame tick and audio clock selection control
`timescale 1ns/1ns
module usb_suspend_frame_clock_ctrl #(
	parameter int frame_cycles        = pwr_frame_pkg::frame_cycles,
	parameter int suspend_idle_cycles = pwr_frame_pkg::suspend_idle_cycles
) (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic pll_locked,
	input  wire logic usb_sof_pulse,
	input  wire logic usb_line_j_state,
	input  wire logic vbus_high,
	input  wire logic suspend_allow_in,
	input  wire logic audio_clock_fast_req,
	output logic      frame_tick,
	output logic      audio_frame_strobe,
	output logic      power_normal,
	output logic      remote_wake,
	output logic      pll_ref_select_crystal,
	output logic      audio_clock_fast,
	output logic      reduced_feature,
	output logic      frame_locked
);
	localparam int cw = $clog2(frame_cycles + 1);
	localparam int iw = $clog2(suspend_idle_cycles + 1);
	localparam logic [cw-1:0] frame_last = cw'(frame_cycles - 1);
	localparam logic [cw-1:0] tick_half  = cw'(frame_cycles / 2);
	localparam logic [cw-1:0] lock_win   = cw'(frame_cycles / 100);
	localparam logic [iw-1:0] idle_last  = iw'(suspend_idle_cycles - 1);

	pwr_frame_pkg::power_state_t state;
	pwr_frame_pkg::power_state_t next_state;
	logic          allow_meta;
	logic          allow_sync;
	logic [cw-1:0] frame_count;
	logic [iw-1:0] idle_count;
	logic          idle_done;
	logic          sof_seen;

	// ****************************************************************
	// input synchronisation
	// ****************************************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			allow_meta <= 1'b0;
			allow_sync <= 1'b0;
		end else begin
			allow_meta <= suspend_allow_in;
			allow_sync <= allow_meta;
		end
	end

	// ****************************************************************
	// frame counter locked to usb start of frame
	// ****************************************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			frame_count <= '0;
			sof_seen    <= 1'b0;
		end else if (usb_sof_pulse) begin
			frame_count <= '0;
			sof_seen    <= 1'b1;
		end else if (frame_count == frame_last) begin
			frame_count <= '0;
		end else begin
			frame_count <= frame_count + cw'(1);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			frame_tick         <= 1'b0;
			audio_frame_strobe <= 1'b0;
			frame_locked       <= 1'b0;
		end else begin
			frame_tick         <= usb_sof_pulse || (frame_count < tick_half - cw'(1)) ||
			                      (frame_count == frame_last);
			audio_frame_strobe <= usb_sof_pulse || (!sof_seen && frame_count == frame_last);
			if (usb_sof_pulse)
				frame_locked <= (frame_count >= frame_last - lock_win) || (frame_count <= lock_win);
			else if (!vbus_high)
				frame_locked <= 1'b0;
		end
	end

	// ****************************************************************
	// bus idle detection
	// ****************************************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			idle_count <= '0;
			idle_done  <= 1'b0;
		end else if (!usb_line_j_state || !vbus_high) begin
			idle_count <= '0;
			idle_done  <= 1'b0;
		end else if (idle_count == idle_last) begin
			idle_done  <= 1'b1;
		end else begin
			idle_count <= idle_count + iw'(1);
		end
	end

	// ****************************************************************
	// power state machine
	// ****************************************************************
	always_comb begin
		next_state = state;
		case (state)
			pwr_frame_pkg::st_clock_wait: begin
				if (pll_locked)
					next_state = pwr_frame_pkg::st_normal;
			end
			pwr_frame_pkg::st_normal: begin
				if (allow_sync && (!vbus_high || idle_done))
					next_state = pwr_frame_pkg::st_low_power;
			end
			pwr_frame_pkg::st_low_power: begin
				if (vbus_high && !usb_line_j_state)
					next_state = pwr_frame_pkg::st_normal;
				else if (vbus_high && !allow_sync)
					next_state = pwr_frame_pkg::st_waking;
			end
			pwr_frame_pkg::st_waking: begin
				if (!usb_line_j_state || !vbus_high)
					next_state = pwr_frame_pkg::st_normal;
			end
			default: next_state = pwr_frame_pkg::st_clock_wait;
		endcase
	end

	// reset of any kind returns to normal power via the clock wait
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			state <= pwr_frame_pkg::st_clock_wait;
		else
			state <= next_state;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			power_normal <= 1'b1;
			remote_wake  <= 1'b0;
		end else begin
			power_normal <= (next_state != pwr_frame_pkg::st_low_power) &&
			                (next_state != pwr_frame_pkg::st_waking);
			remote_wake  <= (next_state == pwr_frame_pkg::st_waking);
		end
	end

	// ****************************************************************
	// clock selection
	// ****************************************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pll_ref_select_crystal <= 1'b1;
			audio_clock_fast       <= 1'b0;
			reduced_feature        <= 1'b1;
		end else begin
			pll_ref_select_crystal <= 1'b1;
			if (state == pwr_frame_pkg::st_clock_wait) begin
				audio_clock_fast <= audio_clock_fast_req;
				reduced_feature  <= !audio_clock_fast_req;
			end
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	sequence s_idle_bus;
		vbus_high && usb_line_j_state && allow_sync;
	endsequence

	a_tick_period: assert property (@(posedge clock) disable iff (!rst_n)
		(frame_count == frame_last && !usb_sof_pulse) |=> frame_count == '0)
		else $error("frame counter did not wrap");
	a_tick_high_after_sof: assert property (@(posedge clock) disable iff (!rst_n)
		usb_sof_pulse |=> frame_tick)
		else $error("frame tick not high after start of frame");
	a_sof_lock: assert property (@(posedge clock) disable iff (!rst_n)
		usb_sof_pulse |=> frame_count == '0 ##1 audio_frame_strobe == 1'b0 || frame_count == cw'(1))
		else $error("frame counter not realigned");
	a_vbus_low_sleep: assert property (@(posedge clock) disable iff (!rst_n)
		(state == pwr_frame_pkg::st_normal && !vbus_high && allow_sync)
		|=> state == pwr_frame_pkg::st_low_power && !power_normal)
		else $error("no low power on disconnect");
	a_idle_sleep: assert property (@(posedge clock) disable iff (!rst_n)
		(state == pwr_frame_pkg::st_normal && idle_done) and s_idle_bus
		|=> state == pwr_frame_pkg::st_low_power)
		else $error("no low power on suspend");
	a_allow_blocks: assert property (@(posedge clock) disable iff (!rst_n)
		(state == pwr_frame_pkg::st_normal && !allow_sync) |=> state != pwr_frame_pkg::st_low_power)
		else $error("low power entered while forbidden");
	a_wake_request: assert property (@(posedge clock) disable iff (!rst_n)
		(state == pwr_frame_pkg::st_low_power && vbus_high && usb_line_j_state && !allow_sync)
		|=> state == pwr_frame_pkg::st_waking && remote_wake)
		else $error("wake-up request ignored");
	a_power_pin: assert property (@(posedge clock) disable iff (!rst_n)
		(state == pwr_frame_pkg::st_low_power) |-> !power_normal)
		else $error("power output high in low power");
	a_sync_delay: assert property (@(posedge clock) disable iff (!rst_n)
		allow_sync == $past(suspend_allow_in, 2) || $past(!rst_n, 2))
		else $error("synchroniser delay wrong");
	a_reduced_slow: assert property (@(posedge clock) disable iff (!rst_n)
		reduced_feature == !audio_clock_fast)
		else $error("reduced mode mismatch");

	// ****************************************************************
	// checks: frame timing
	// ****************************************************************
	a_tick_high_half: assert property (@(posedge clock) disable iff (!rst_n)
		(frame_count < tick_half - cw'(1) && !usb_sof_pulse)
		|=> frame_tick)
		else $error("frame tick low in first half");
	a_tick_low_half: assert property (@(posedge clock) disable iff (!rst_n)
		(frame_count >= tick_half - cw'(1) && frame_count != frame_last && !usb_sof_pulse)
		|=> !frame_tick)
		else $error("frame tick high in second half");
	a_strobe_after_sof: assert property (@(posedge clock) disable iff (!rst_n)
		usb_sof_pulse
		|=> audio_frame_strobe)
		else $error("no audio strobe after start of frame");
	a_strobe_only_sof: assert property (@(posedge clock) disable iff (!rst_n)
		(!usb_sof_pulse && sof_seen)
		|=> !audio_frame_strobe)
		else $error("audio strobe without start of frame");
	a_lock_on_time: assert property (@(posedge clock) disable iff (!rst_n)
		(usb_sof_pulse && frame_count == frame_last)
		|=> frame_locked)
		else $error("lock flag low for timely frame");
	a_unlock_vbus: assert property (@(posedge clock) disable iff (!rst_n)
		(!vbus_high && !usb_sof_pulse)
		|=> !frame_locked)
		else $error("lock flag kept without bus supply");

	// ****************************************************************
	// checks: power state
	// ****************************************************************
	sequence s_bus_active;
		vbus_high && !usb_line_j_state;
	endsequence

	a_idle_restart: assert property (@(posedge clock) disable iff (!rst_n)
		(!usb_line_j_state || !vbus_high)
		|=> !idle_done)
		else $error("idle flag kept on bus activity");
	a_wake_exit: assert property (@(posedge clock) disable iff (!rst_n)
		(state == pwr_frame_pkg::st_waking) and s_bus_active
		|=> state == pwr_frame_pkg::st_normal)
		else $error("waking state not left on bus activity");
	a_resume_exit: assert property (@(posedge clock) disable iff (!rst_n)
		(state == pwr_frame_pkg::st_low_power) and s_bus_active
		|=> state == pwr_frame_pkg::st_normal && power_normal)
		else $error("low power not left on bus activity");
	a_waking_pins: assert property (@(posedge clock) disable iff (!rst_n)
		(state == pwr_frame_pkg::st_waking)
		|-> !power_normal && remote_wake)
		else $error("power pins wrong while waking");
	a_normal_pins: assert property (@(posedge clock) disable iff (!rst_n)
		(state == pwr_frame_pkg::st_normal || state == pwr_frame_pkg::st_clock_wait)
		|-> power_normal && !remote_wake)
		else $error("power pins wrong in normal power");
	a_clock_wait_hold: assert property (@(posedge clock) disable iff (!rst_n)
		(state == pwr_frame_pkg::st_clock_wait && !pll_locked)
		|=> state == pwr_frame_pkg::st_clock_wait)
		else $error("left clock wait before lock");
	a_clock_wait_exit: assert property (@(posedge clock) disable iff (!rst_n)
		(state == pwr_frame_pkg::st_clock_wait && pll_locked)
		|=> state == pwr_frame_pkg::st_normal)
		else $error("clock wait not left after lock");

	// ****************************************************************
	// checks: clock selection
	// ****************************************************************
	a_crystal_ref: assert property (@(posedge clock) disable iff (!rst_n)
		1'b1
		|-> pll_ref_select_crystal)
		else $error("pll reference not the crystal");
	a_clock_frozen: assert property (@(posedge clock) disable iff (!rst_n)
		(state != pwr_frame_pkg::st_clock_wait)
		|=> $stable(audio_clock_fast))
		else $error("clock select changed in operation");
	a_fast_follows: assert property (@(posedge clock) disable iff (!rst_n)
		(state == pwr_frame_pkg::st_clock_wait)
		|=> audio_clock_fast == $past(audio_clock_fast_req))
		else $error("clock select not latched in clock wait");
	a_slow_reduced: assert property (@(posedge clock) disable iff (!rst_n)
		!audio_clock_fast
		|-> reduced_feature)
		else $error("slow clock without reduced mode");
endmodule : usb_suspend_frame_clock_ctrl

// >>> sim/usb_host_model.sv
// usb host and board model: frame markers, idle line state, bus supply
`timescale 1ns/1ns
module usb_host_model #(
	parameter int period = 100
) (
	input  wire logic clock,
	input  wire logic active,
	input  wire logic supply_on,
	output logic      sof_pulse,
	output logic      line_j,
	output logic      vbus
);
	int count = 0;
	// an idle host leaves the lines in J and sends no frame markers
	assign line_j = !active;
	assign vbus = supply_on;
	always @(posedge clock) begin
		count <= (!active || count == period - 1) ? 0 : count + 1;
		sof_pulse <= active && count == period - 1;
	end
endmodule : usb_host_model

// >>> sim/usb_suspend_frame_clock_ctrl_tb.sv
// self-checking bench for the suspend, frame tick and audio clock control
`timescale 1ns/1ns
module usb_suspend_frame_clock_ctrl_tb;
	localparam int frame = 100;
	localparam int idle  = 20;
	logic clock = 1'b0, rst_n = 1'b0, pll_locked = 1'b0, allow = 1'b1, fast_req = 1'b1;
	logic active = 1'b0, supply_on = 1'b1;
	logic sof, line_j, vbus, tick, strobe, power_normal, wake, crystal, fast, reduced, locked;
	int   n_errors = 0;
	int   compares = 0;
	int   highs, strobes;
	usb_host_model #(.period(frame)) i_host (.clock(clock), .active(active), .supply_on(supply_on),
		.sof_pulse(sof), .line_j(line_j), .vbus(vbus));
	usb_suspend_frame_clock_ctrl #(.frame_cycles(frame), .suspend_idle_cycles(idle)) i_dut (
		.clock(clock), .rst_n(rst_n), .pll_locked(pll_locked), .usb_sof_pulse(sof),
		.usb_line_j_state(line_j), .vbus_high(vbus), .suspend_allow_in(allow),
		.audio_clock_fast_req(fast_req), .frame_tick(tick), .audio_frame_strobe(strobe),
		.power_normal(power_normal), .remote_wake(wake), .pll_ref_select_crystal(crystal),
		.audio_clock_fast(fast), .reduced_feature(reduced), .frame_locked(locked));
	initial begin
		forever #5 clock = !clock;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic cycles(input int n);
		repeat (n) @(negedge clock);
	endtask : cycles
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run
	task automatic t_start;
		check(power_normal, 1'b1);
		check(crystal, 1'b1);
		check(reduced, 1'b1);
		rst_n = 1'b1;
		cycles(3);
		pll_locked = 1'b1;
		active = 1'b1;
		cycles(3);
		fast_req = 1'b0;
		cycles(3);
		check(fast, 1'b1);
		check(reduced, 1'b0);
		$display("t_start done");
	endtask : t_start
	task automatic t_frame;
		cycles(2 * frame);
		highs = 0;
		strobes = 0;
		repeat (4 * frame) begin
			@(negedge clock);
			highs += (tick === 1'b1);
			strobes += (strobe === 1'b1);
		end
		check(highs, 2 * frame);
		check(strobes, 4);
		check(locked, 1'b1);
		$display("t_frame done");
	endtask : t_frame
	task automatic t_vbus;
		supply_on = 1'b0;
		cycles(3);
		check(power_normal, 1'b0);
		supply_on = 1'b1;
		cycles(3);
		check(power_normal, 1'b1);
		$display("t_vbus done");
	endtask : t_vbus
	task automatic t_block;
		allow = 1'b0;
		active = 1'b0;
		cycles(idle + 10);
		check(power_normal, 1'b1);
		allow = 1'b1;
		cycles(idle + 10);
		check(power_normal, 1'b0);
		$display("t_block done");
	endtask : t_block
	task automatic t_wake;
		allow = 1'b0;
		cycles(1);
		check(wake, 1'b0);
		cycles(3);
		check(wake, 1'b1);
		check(power_normal, 1'b0);
		allow = 1'b1;
		active = 1'b1;
		cycles(4);
		check(power_normal, 1'b1);
		check(wake, 1'b0);
		$display("t_wake done");
	endtask : t_wake
	task automatic t_restart;
		active = 1'b0;
		cycles(idle + 10);
		check(power_normal, 1'b0);
		rst_n = 1'b0;
		pll_locked = 1'b0;
		fast_req = 1'b0;
		cycles(1);
		check(power_normal, 1'b1);
		cycles(4);
		rst_n = 1'b1;
		cycles(2);
		pll_locked = 1'b1;
		active = 1'b1;
		cycles(3);
		check(fast, 1'b0);
		check(reduced, 1'b1);
		check(power_normal, 1'b1);
		$display("t_restart done");
	endtask : t_restart
	initial begin
		cycles(5);
		t_start();
		t_frame();
		t_vbus();
		t_block();
		t_wake();
		t_restart();
		complete_run();
	end
	// the whole sequence needs about 730 cycles
	initial begin
		#50000;
		n_errors++;
		complete_run();
	end
endmodule : usb_suspend_frame_clock_ctrl_tb
